// [common/tes_pkg.sv]
// Summary of operation
// - a frame trigger comes from the external pin or a software command
// - the trigger pin polarity is selectable, high active or low active
// - edge mode exposes once per trigger for the programmed exposure time
// - level mode exposes for as long as the filtered pin trigger, or the software trigger when selected, stays active
// - burst mode exposes and transfers several frames from one trigger
// - a fixed nonzero latency lies between trigger and exposure start
// - a programmable delay is added before exposure starts
// - the trigger pin passes spike rejection and debounce filters
// - an event pulse marks each accepted trigger
// - an event pulse marks each rejected trigger
// - an event pulse marks the start of waiting for a trigger
// - event pulses mark start and end of each usb frame transfer
// - event pulses mark start and end of each exposure
// - event pulses mark start and end of each strobe pulse, after the strobe delay
// - strobe output with configurable delay and pulse width
// - a software level output follows a host setting directly
// - integration window output is high from exposure start to end
// - capture busy is high from exposure start until readout completes
// - usb send busy is high while image data is sent
// - awaiting indication high while ready; a trigger then starts exposure
// - manual exposure time counts in one microsecond steps
package tes_pkg;
	localparam int CLK_MHZ = 25;
	localparam int US_NS = 1000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
	localparam int LATENCY_CYC = 2;
	localparam int TIME_W = 24;
	localparam int FILT_W = 16;
	localparam int BURST_W = 8;
	localparam logic [1:0] MODE_EDGE = 2'h0;
	localparam logic [1:0] MODE_LEVEL = 2'h1;
	localparam logic [1:0] MODE_BURST = 2'h2;

	typedef enum logic [6:0] {
		ST_WAIT = 7'h01,
		ST_LAT = 7'h02,
		ST_DELAY = 7'h04,
		ST_EXPO = 7'h08,
		ST_READ = 7'h10,
		ST_SEND = 7'h20,
		ST_GAP = 7'h40
	} tes_state_type;

	typedef struct packed {
		logic trigger_accepted;
		logic trigger_rejected;
		logic awaiting_trigger;
		logic usb_send_begin;
		logic usb_send_finish;
		logic integration_begin;
		logic integration_finish;
		logic strobe_timer_begin;
		logic strobe_timer_finish;
	} tes_event_type;

	typedef struct packed {
		logic [1:0] mode;
		logic active_low;
		logic use_software;
		logic [TIME_W-1:0] exposure_us;
		logic [TIME_W-1:0] delay_us;
		logic [BURST_W-1:0] burst_frame_count;
		logic [FILT_W-1:0] glitch_cyc;
		logic [FILT_W-1:0] debounce_cyc;
	} tes_cfg_type;
endpackage

// [rtl/tes_filter.sv]
`timescale 1ns/100ps
// polarity correction, spike rejection and debounce of the trigger pin
module tes_filter import tes_pkg::*; #(
	parameter int W = FILT_W
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// pin and settings
	input wire logic i_pin,
	input wire logic i_active_low,
	input wire logic [W-1:0] i_glitch_cyc,
	input wire logic [W-1:0] i_debounce_cyc,
	// cleaned active-high level
	output logic o_level
);
	initial if (W < 2) $error("filter width too small");
	logic raw;
	logic glitch_ff;
	logic [W-1:0] gcnt_ff;
	logic [W-1:0] dcnt_ff;
	logic hold_ff;
	logic level_ff;

	assign raw = i_pin ^ i_active_low;

	// spike rejection: a new level must persist glitch_cyc + 1 cycles
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			glitch_ff <= 1'b0;
			gcnt_ff <= '0;
		end else if (raw == glitch_ff) begin
			gcnt_ff <= '0;
		end else if (gcnt_ff >= i_glitch_cyc) begin
			glitch_ff <= raw;
			gcnt_ff <= '0;
		end else begin
			gcnt_ff <= gcnt_ff + 1'b1;
		end
	end

	// debounce: after a change the output holds for debounce_cyc + 2 cycles
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			level_ff <= 1'b0;
			dcnt_ff <= '0;
			hold_ff <= 1'b0;
		end else if (hold_ff) begin
			if (dcnt_ff >= i_debounce_cyc) hold_ff <= 1'b0;
			else dcnt_ff <= dcnt_ff + 1'b1;
		end else if (glitch_ff != level_ff) begin
			level_ff <= glitch_ff;
			dcnt_ff <= '0;
			hold_ff <= 1'b1;
		end
	end

	assign o_level = level_ff;
endmodule

// [rtl/tes_strobe.sv]
`timescale 1ns/100ps
// strobe timer: delay then pulse, both in microsecond ticks
module tes_strobe import tes_pkg::*; #(
	parameter int W = TIME_W
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// control
	input wire logic i_start,
	input wire logic i_us_tick,
	input wire logic [W-1:0] i_delay_us,
	input wire logic [W-1:0] i_width_us,
	// results
	output logic o_pulse,
	output logic o_begin,
	output logic o_finish
);
	initial if (W < 2) $error("strobe width too small");
	logic [W-1:0] cnt_ff;
	logic wait_ff;
	logic pulse_ff;
	logic begin_ff;
	logic finish_ff;

	// sequence delay then pulse; a zero width yields no pulse
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_ff <= '0;
			wait_ff <= 1'b0;
			pulse_ff <= 1'b0;
			begin_ff <= 1'b0;
			finish_ff <= 1'b0;
		end else begin
			begin_ff <= 1'b0;
			finish_ff <= 1'b0;
			if (i_start && !wait_ff && !pulse_ff) begin
				wait_ff <= 1'b1;
				cnt_ff <= '0;
			end else if (wait_ff && (cnt_ff >= i_delay_us)) begin
				wait_ff <= 1'b0;
				cnt_ff <= '0;
				if (i_width_us != '0) begin
					pulse_ff <= 1'b1;
					begin_ff <= 1'b1;
				end
			end else if (pulse_ff && (cnt_ff >= i_width_us)) begin
				pulse_ff <= 1'b0;
				finish_ff <= 1'b1;
			end else if ((wait_ff || pulse_ff) && i_us_tick) begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	assign o_pulse = pulse_ff;
	assign o_begin = begin_ff;
	assign o_finish = finish_ff;
endmodule

// [rtl/tes_sequencer.sv]
`timescale 1ns/100ps
// trigger and exposure sequencer top
module tes_sequencer import tes_pkg::*; #(
	parameter int TW = TIME_W,
	parameter int FW = FILT_W,
	parameter int BW = BURST_W,
	parameter int LAT = LATENCY_CYC
) (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// trigger sources
	input wire logic I_TRIG_PIN,
	input wire logic I_SW_TRIG,
	// configuration
	input wire tes_cfg_type I_CFG,
	input wire logic [TW-1:0] I_STROBE_DELAY_US,
	input wire logic [TW-1:0] I_STROBE_WIDTH_US,
	input wire logic I_SOFTWARE_LEVEL,
	input wire logic [2:0] I_GPIO_SEL,
	// readout and usb handshakes from the datapath
	input wire logic I_READOUT_DONE,
	input wire logic I_USB_DONE,
	// status outputs
	output logic O_INTEGRATION_WINDOW,
	output logic O_CAPTURE_BUSY,
	output logic O_USB_SEND_BUSY,
	output logic O_AWAITING_TRIGGER,
	output logic O_STROBE_PULSE,
	output logic O_SOFTWARE_LEVEL,
	output logic O_GPIO,
	// events, one-cycle pulses
	output tes_event_type O_EVENT
);
	initial if (TW != TIME_W || FW != FILT_W || BW != BURST_W || LAT < 1)
		$error("unsupported parameter values");

	tes_state_type state_ff, nxt_state;
	logic level;
	logic level_d_ff;
	logic rise;
	logic trig;
	logic [4:0] tick_cnt_ff;
	logic us_tick;
	logic [TW-1:0] cnt_ff;
	logic [4:0] phase_ff;
	logic [BW-1:0] frames_ff;
	logic [7:0] lat_ff;
	logic strobe_begin;
	logic strobe_finish;
	logic strobe_pulse;
	logic wait_start_ff;
	logic cap_ff;
	logic [1:0] mode_ff;
	tes_event_type ev_ff;

	// cleaned trigger level, polarity applied first
	tes_filter #(.W(FW)) u_filter (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_pin(I_TRIG_PIN),
		.i_active_low(I_CFG.active_low),
		.i_glitch_cyc(I_CFG.glitch_cyc),
		.i_debounce_cyc(I_CFG.debounce_cyc),
		.o_level(level)
	);

	// strobe timer launched at each exposure start that finds it idle
	tes_strobe #(.W(TW)) u_strobe (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_start(ev_ff.integration_begin),
		.i_us_tick(us_tick),
		.i_delay_us(I_STROBE_DELAY_US),
		.i_width_us(I_STROBE_WIDTH_US),
		.o_pulse(strobe_pulse),
		.o_begin(strobe_begin),
		.o_finish(strobe_finish)
	);

	// one microsecond tick divider
	always_ff @(posedge I_CLK) begin
		if (I_RST) tick_cnt_ff <= '0;
		else if (tick_cnt_ff == 5'(CYC_PER_US - 1)) tick_cnt_ff <= '0;
		else tick_cnt_ff <= tick_cnt_ff + 1'b1;
	end
	assign us_tick = (tick_cnt_ff == 5'(CYC_PER_US - 1));

	// edge detection on the filtered level
	always_ff @(posedge I_CLK) begin
		if (I_RST) level_d_ff <= 1'b0;
		else level_d_ff <= level;
	end
	assign rise = level && !level_d_ff;
	assign trig = I_CFG.use_software ? I_SW_TRIG : rise;

	// next state
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_WAIT: if (trig) nxt_state = ST_LAT;
			ST_LAT: if (lat_ff == 8'(LAT - 1)) nxt_state = ST_DELAY;
			ST_DELAY: if (cnt_ff >= I_CFG.delay_us) nxt_state = ST_EXPO;
			ST_EXPO: begin
				if (mode_ff == MODE_LEVEL) begin
					if (!(I_CFG.use_software ? I_SW_TRIG : level)) nxt_state = ST_READ;
				end else if (cnt_ff >= I_CFG.exposure_us) begin
					nxt_state = ST_READ;
				end
			end
			ST_READ: if (I_READOUT_DONE) nxt_state = ST_SEND;
			ST_SEND: begin
				if (I_USB_DONE) begin
					if (mode_ff == MODE_BURST && frames_ff > 8'(1)) nxt_state = ST_GAP;
					else nxt_state = ST_WAIT;
				end
			end
			ST_GAP: nxt_state = ST_EXPO;
			default: nxt_state = ST_WAIT;
		endcase
	end

	// state register
	always_ff @(posedge I_CLK) begin
		if (I_RST) state_ff <= ST_WAIT;
		else state_ff <= nxt_state;
	end

	// latency and microsecond counters; the phase restarts at each state entry so
	// delay and exposure last whole microseconds, not up to one tick short
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			lat_ff <= '0;
			cnt_ff <= '0;
			phase_ff <= '0;
		end else if (state_ff != nxt_state) begin
			lat_ff <= '0;
			cnt_ff <= '0;
			phase_ff <= '0;
		end else begin
			if (state_ff == ST_LAT) lat_ff <= lat_ff + 1'b1;
			if (phase_ff == 5'(CYC_PER_US - 1)) begin
				phase_ff <= '0;
				cnt_ff <= cnt_ff + 1'b1;
			end else begin
				phase_ff <= phase_ff + 1'b1;
			end
		end
	end

	// mode and burst count latched on acceptance
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			mode_ff <= MODE_EDGE;
			frames_ff <= '0;
		end else if (state_ff == ST_WAIT && trig) begin
			mode_ff <= I_CFG.mode;
			frames_ff <= I_CFG.burst_frame_count;
		end else if (state_ff == ST_SEND && I_USB_DONE && frames_ff != '0) begin
			frames_ff <= frames_ff - 1'b1;
		end
	end

	// capture busy from exposure start until readout completes
	always_ff @(posedge I_CLK) begin
		if (I_RST) cap_ff <= 1'b0;
		else if (state_ff != ST_EXPO && nxt_state == ST_EXPO) cap_ff <= 1'b1;
		else if (state_ff == ST_READ && I_READOUT_DONE) cap_ff <= 1'b0;
	end

	// wait-start marker on each rise of the awaiting level, the first after reset too
	always_ff @(posedge I_CLK) begin
		if (I_RST) wait_start_ff <= 1'b0;
		else wait_start_ff <= nxt_state == ST_WAIT && !O_AWAITING_TRIGGER;
	end

	// event pulses
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ev_ff <= '0;
		end else begin
			ev_ff.trigger_accepted <= state_ff == ST_WAIT && trig;
			ev_ff.trigger_rejected <= state_ff != ST_WAIT && trig;
			ev_ff.awaiting_trigger <= wait_start_ff;
			ev_ff.integration_begin <= state_ff != ST_EXPO && nxt_state == ST_EXPO;
			ev_ff.integration_finish <= state_ff == ST_EXPO && nxt_state != ST_EXPO;
			ev_ff.usb_send_begin <= state_ff != ST_SEND && nxt_state == ST_SEND;
			ev_ff.usb_send_finish <= state_ff == ST_SEND && nxt_state != ST_SEND;
			ev_ff.strobe_timer_begin <= strobe_begin;
			ev_ff.strobe_timer_finish <= strobe_finish;
		end
	end

	// status outputs
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_INTEGRATION_WINDOW <= 1'b0;
			O_USB_SEND_BUSY <= 1'b0;
			O_AWAITING_TRIGGER <= 1'b0;
			O_SOFTWARE_LEVEL <= 1'b0;
		end else begin
			O_INTEGRATION_WINDOW <= nxt_state == ST_EXPO;
			O_USB_SEND_BUSY <= nxt_state == ST_SEND;
			O_AWAITING_TRIGGER <= nxt_state == ST_WAIT;
			O_SOFTWARE_LEVEL <= I_SOFTWARE_LEVEL;
		end
	end

	// selectable gpio pin
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_GPIO <= 1'b0;
		end else begin
			unique case (I_GPIO_SEL)
				3'h0: O_GPIO <= strobe_pulse;
				3'h1: O_GPIO <= I_SOFTWARE_LEVEL;
				3'h2: O_GPIO <= nxt_state == ST_EXPO;
				3'h3: O_GPIO <= cap_ff;
				3'h4: O_GPIO <= nxt_state == ST_SEND;
				3'h5: O_GPIO <= nxt_state == ST_WAIT;
				default: O_GPIO <= 1'b0;
			endcase
		end
	end

	assign O_CAPTURE_BUSY = cap_ff;
	assign O_STROBE_PULSE = strobe_pulse;
	assign O_EVENT = ev_ff;
endmodule

// [test/tes_sequencer_properties.sv]
`timescale 1ns/100ps
// timing relations between the sequencer's status levels and event pulses
module tes_sequencer_properties import tes_pkg::*; (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// watched outputs
	input wire logic O_INTEGRATION_WINDOW,
	input wire logic O_CAPTURE_BUSY,
	input wire logic O_USB_SEND_BUSY,
	input wire logic O_AWAITING_TRIGGER,
	input wire tes_event_type O_EVENT
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	// exposure and send events pulse in the cycle the level changes
	win_begin_a: assert property ($rose(O_INTEGRATION_WINDOW) |-> O_EVENT.integration_begin)
		else $error("no exposure begin event");
	win_end_a: assert property ($fell(O_INTEGRATION_WINDOW) |-> O_EVENT.integration_finish)
		else $error("no exposure end event");
	usb_begin_a: assert property ($rose(O_USB_SEND_BUSY) |-> O_EVENT.usb_send_begin)
		else $error("no send begin event");
	usb_end_a: assert property ($fell(O_USB_SEND_BUSY) |-> O_EVENT.usb_send_finish)
		else $error("no send end event");
	wait_event_a: assert property ($rose(O_AWAITING_TRIGGER) |=> O_EVENT.awaiting_trigger)
		else $error("no awaiting event");
	// capture busy covers the whole exposure
	busy_in_win_a: assert property (O_INTEGRATION_WINDOW |-> O_CAPTURE_BUSY)
		else $error("window without capture busy");
	// accept only while waiting, reject only while not
	accept_wait_a: assert property (O_EVENT.trigger_accepted |-> $past(O_AWAITING_TRIGGER))
		else $error("accept while not waiting");
	reject_busy_a: assert property (O_EVENT.trigger_rejected |-> !$past(O_AWAITING_TRIGGER))
		else $error("reject while waiting");
	// exposure never opens at once after acceptance
	lat_gap_a: assert property (O_EVENT.trigger_accepted |-> !O_INTEGRATION_WINDOW ##1 !O_INTEGRATION_WINDOW)
		else $error("exposure without latency");
	// main scenarios
	cover property (O_EVENT.trigger_rejected);
	cover property (O_EVENT.strobe_timer_finish);
	cover property (O_EVENT.usb_send_finish);
endmodule

bind tes_sequencer tes_sequencer_properties tes_sequencer_properties_i (.I_CLK(I_CLK),
	.I_RST(I_RST), .O_INTEGRATION_WINDOW(O_INTEGRATION_WINDOW), .O_CAPTURE_BUSY(O_CAPTURE_BUSY),
	.O_USB_SEND_BUSY(O_USB_SEND_BUSY), .O_AWAITING_TRIGGER(O_AWAITING_TRIGGER), .O_EVENT(O_EVENT));

// [test/tes_far_end.sv]
`timescale 1ns/100ps
// readout path and usb host: completion pulses after a set lag
module tes_far_end (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// sequencer status and answer lag
	input wire logic i_win,
	input wire logic i_cap,
	input wire logic i_usb,
	input wire logic [7:0] i_lag,
	// completion pulses
	output logic o_rd_done,
	output logic o_usb_done
);
	logic [7:0] rd_ff;
	logic [7:0] us_ff;
	// readout ends i_lag cycles after exposure; one pulse only
	always_ff @(posedge i_clk) begin
		rd_ff <= (i_rst || !i_cap || i_win || i_usb) ? 8'h00 : rd_ff + 8'h01;
		o_rd_done <= !i_rst && i_cap && !i_win && !i_usb && rd_ff == i_lag;
	end
	// host takes the frame i_lag cycles after send starts
	always_ff @(posedge i_clk) begin
		us_ff <= (i_rst || !i_usb) ? 8'h00 : us_ff + 8'h01;
		o_usb_done <= !i_rst && i_usb && us_ff == i_lag;
	end
endmodule

// [test/tes_sequencer_tb_top.sv]
`timescale 1ns/100ps
module tes_sequencer_tb_top import tes_pkg::*;;
	logic clk = 1'b0, rst = 1'b1, pin = 1'b0, sw = 1'b0, slv = 1'b0;
	tes_cfg_type cfg = '0;
	logic [TIME_W-1:0] sdl = 24'h000001, swd = 24'h000002;
	logic [2:0] gsel = 3'h0;
	logic [7:0] lag = 8'h28;
	logic rdd, usd, win, cap, usb, awt, stb, slo, gpo;
	tes_event_type ev;
	int err_total, checks_done, cyc, t_acc, t_win, win_c, stb_c, gp_c;
	int n[9];

	tes_sequencer tes_sequencer_i (.I_CLK(clk), .I_RST(rst), .I_TRIG_PIN(pin), .I_SW_TRIG(sw),
		.I_CFG(cfg), .I_STROBE_DELAY_US(sdl), .I_STROBE_WIDTH_US(swd), .I_SOFTWARE_LEVEL(slv),
		.I_GPIO_SEL(gsel), .I_READOUT_DONE(rdd), .I_USB_DONE(usd), .O_INTEGRATION_WINDOW(win),
		.O_CAPTURE_BUSY(cap), .O_USB_SEND_BUSY(usb), .O_AWAITING_TRIGGER(awt),
		.O_STROBE_PULSE(stb), .O_SOFTWARE_LEVEL(slo), .O_GPIO(gpo), .O_EVENT(ev));
	tes_far_end tes_far_end_i (.i_clk(clk), .i_rst(rst), .i_win(win), .i_cap(cap), .i_usb(usb),
		.i_lag(lag), .o_rd_done(rdd), .o_usb_done(usd));

	// 25 MHz clock
	initial begin
		forever #20 clk = ~clk;
	end

	// tally event pulses and level widths
	always @(posedge clk) begin
		cyc <= cyc + 1;
		for (int i = 0; i < 9; i++) if (ev[i] === 1'b1) n[i] <= n[i] + 1;
		if (ev.trigger_accepted === 1'b1) t_acc <= cyc;
		if (ev.integration_begin === 1'b1) t_win <= cyc - 1;
		win_c <= win_c + int'(win === 1'b1);
		stb_c <= stb_c + int'(stb === 1'b1);
		gp_c <= gp_c + int'(gpo === 1'b1);
	end

	task automatic fail(input string nm, input int ex, input int got);
		err_total++;
		$display("[FAIL] %s expected %0d seen %0d", nm, ex, got);
	endtask
	task automatic chk(input string nm, input int ex, input int got);
		checks_done++;
		if (ex != got) fail(nm, ex, got);
	endtask
	task automatic chkr(input string nm, input int lo, input int hi, input int got);
		checks_done++;
		if (got < lo || got > hi) fail(nm, lo, got);
	endtask
	task automatic chkb(input string nm, input logic ex, input logic got);
		checks_done++;
		if (got !== ex) fail(nm, ex, got);
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// settings change only while idle; pin parked at its inactive level
	task automatic setup(input logic [1:0] m, input logic al, input logic us, input int e,
		input int d, input int bc, input int g);
		@(posedge clk);
		pin <= al;
		cfg <= '{m, al, us, TIME_W'(e), TIME_W'(d), BURST_W'(bc), FILT_W'(g), FILT_W'(2)};
		repeat (20) @(posedge clk);
		@(negedge clk);
		n = '{default: 0};
		win_c = 0;
		stb_c = 0;
		gp_c = 0;
		@(posedge clk);
	endtask
	// bounded wait for the sequencer to wait for a trigger again
	task automatic wait_idle();
		int k;
		k = 0;
		repeat (3) @(posedge clk);
		while (awt !== 1'b1) begin
			@(posedge clk);
			k++;
			if (k > 20000) begin
				fail("idle wait", 1, 0);
				report_and_stop();
			end
		end
		repeat (100) @(posedge clk);
	endtask
	task automatic fire_sw();
		sw <= 1'b1;
		@(posedge clk);
		sw <= 1'b0;
	endtask
	task automatic pin_pulse(input logic act, input int w);
		pin <= act;
		repeat (w) @(posedge clk);
		pin <= ~act;
		@(posedge clk);
	endtask

	// pin edge trigger, 3 us exposure, 2 us delay, strobe 1 us then 2 us
	task automatic s_edge();
		gsel <= 3'h2;
		setup(MODE_EDGE, 1'b0, 1'b0, 3, 2, 0, 2);
		pin_pulse(1'b1, 20);
		wait_idle();
		chk("accepted", 1, n[8]);
		chk("awaiting ev", 1, n[6]);
		chk("send begin", 1, n[5]);
		chk("send end", 1, n[4]);
		chk("expo begin", 1, n[3]);
		chk("expo end", 1, n[2]);
		chk("strobe begin", 1, n[1]);
		chk("strobe end", 1, n[0]);
		chkr("expo cycles", 3 * CYC_PER_US, 4 * CYC_PER_US + 2, win_c);
		chkr("delay", LATENCY_CYC + 2 * CYC_PER_US, LATENCY_CYC + 3 * CYC_PER_US + 2, t_win - t_acc);
		chkr("strobe cycles", CYC_PER_US + 1, 3 * CYC_PER_US + 2, stb_c);
		chk("gpio window", win_c, gp_c);
	endtask
	// low-active pin held 200 cycles in level mode
	task automatic s_level();
		setup(MODE_LEVEL, 1'b1, 1'b0, 1, 0, 0, 2);
		pin_pulse(1'b0, 200);
		wait_idle();
		chk("level accepted", 1, n[8]);
		chkr("level cycles", 188, 208, win_c);
	endtask
	// one software trigger, three frames, prompt far side
	task automatic s_burst();
		setup(MODE_BURST, 1'b0, 1'b1, 1, 0, 3, 2);
		lag <= 8'h02;
		fire_sw();
		wait_idle();
		chk("burst accepted", 1, n[8]);
		chk("burst expos", 3, n[3]);
		chk("burst sends", 3, n[5]);
		lag <= 8'h28;
	endtask
	// second trigger while busy is refused
	task automatic s_reject();
		setup(MODE_EDGE, 1'b0, 1'b1, 2, 0, 0, 2);
		fire_sw();
		repeat (5) @(posedge clk);
		fire_sw();
		wait_idle();
		chk("rej accepted", 1, n[8]);
		chk("rejected", 1, n[7]);
		chk("rej expos", 1, n[3]);
	endtask
	// short spike ignored, clean pulse taken
	task automatic s_glitch();
		setup(MODE_EDGE, 1'b0, 1'b0, 1, 0, 0, 6);
		pin_pulse(1'b1, 2);
		repeat (60) @(posedge clk);
		chk("spike", 0, n[8]);
		chkb("still waiting", 1'b1, awt);
		pin_pulse(1'b1, 20);
		wait_idle();
		chk("clean pulse", 1, n[8]);
	endtask
	// user level on its own pin and through the selector
	task automatic s_gpio();
		gsel <= 3'h1;
		for (int v = 1; v >= 0; v--) begin
			slv <= v[0];
			repeat (4) @(posedge clk);
			chkb("user level", v[0], slo);
			chkb("gpio user", v[0], gpo);
		end
		gsel <= 3'h5;
		repeat (4) @(posedge clk);
		chkb("gpio waiting", 1'b1, gpo);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wait_idle();
		s_edge();
		s_level();
		s_burst();
		s_reject();
		s_glitch();
		s_gpio();
		report_and_stop();
	end
endmodule
